// >>> rtl/ddc_regs.vh
`ifndef DDC_REGS_VH
`define DDC_REGS_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define DDC_ADDR_STATUS   4'h0
`define DDC_ADDR_MASK     4'h4
`define DDC_ADDR_CTRL     4'h8
`define DDC_ADDR_STATE    4'hC

// Status and mask bit positions
`define DDC_EV_START      0
`define DDC_EV_END        1
`define DDC_EV_COIL_FLT   2
`define DDC_EV_AMB_FLT    3
`define DDC_EV_W          4

// Reset values
`define DDC_MASK_RST      4'h0
`define DDC_CTRL_RST      1'b1

// ****************************************************************
// Temperatures in degrees F, signed 8 bit
// ****************************************************************
`define DDC_COLD_F        8'sh23
`define DDC_TERM_50_F     8'sh32
`define DDC_TERM_70_F     8'sh46
`define DDC_TERM_80_F     8'sh50
`define DDC_DELTA_F       8'sh0A

// Jumper positions
`define DDC_JMP_50        2'h1
`define DDC_JMP_80        2'h2

// ****************************************************************
// Times and rates
// ****************************************************************
`define DDC_CLK_HZ        20000000
`define DDC_TICK_S        1
`define DDC_DEMAND_MIN    34
`define DDC_BACKSTOP_H    6
`define DDC_DEFROST_MIN   14
`define DDC_SEC_PER_MIN   60
`define DDC_MIN_PER_H     60
`define DDC_TEST_SPEEDUP  240
`define DDC_LED_SLOT_MS   250
`define DDC_MS_PER_S      1000

// LED flash codes
`define DDC_CODE_STEADY   2'h0
`define DDC_CODE_DEFROST  2'h1
`define DDC_CODE_COIL     2'h2
`define DDC_CODE_AMB      2'h3

`endif

// >>> rtl/ddc_defrost_ctrl.v
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "ddc_regs.vh"

// Overview of operation
// - Demand defrost needs coil below 35F, 34 minutes cold run, and large delta.
// - Ambient minus coil difference is compared against a threshold for demand start.
// - Six hours cold compressor run since last defrost forces a defrost.
// - Defrost lasts until fourteen minutes pass or coil reaches termination temperature.
// - Termination temperature is 70F by default, jumper selects 50F, 70F or 80F.
// - With ambient sensor failed, defrost every 34 minutes of cold running.
// - With coil sensor failed, no defrost is ever started.
// - Test short enters test mode: temperature enable ignored, timers 240x, manual defrost.
// - Test-started defrost still ends on 14 minutes or termination temperature.
// - Shorting the test pins again ends a test-started defrost at once.
// - LED steady on normally; 1 flash defrost, 2 coil fault, 3 ambient fault.
module ddc_defrost_ctrl #(
    parameter        P_TICK_CYC    = `DDC_CLK_HZ * `DDC_TICK_S,
    parameter        P_LED_CYC     = `DDC_CLK_HZ / `DDC_MS_PER_S * `DDC_LED_SLOT_MS,
    parameter        P_DEMAND_SEC  = `DDC_DEMAND_MIN * `DDC_SEC_PER_MIN,
    parameter        P_BACKSTOP_SEC = `DDC_BACKSTOP_H * `DDC_MIN_PER_H * `DDC_SEC_PER_MIN,
    parameter        P_DEFROST_SEC = `DDC_DEFROST_MIN * `DDC_SEC_PER_MIN,
    parameter [7:0]  P_DELTA_F     = `DDC_DELTA_F
) (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    input  wire [7:0]  i_amb_temp,
    input  wire [7:0]  i_coil_temp,
    input  wire        i_amb_fail,
    input  wire        i_coil_fail,
    input  wire        i_comp_run,
    input  wire        i_test_short,
    input  wire [1:0]  i_term_jmp,
    input  wire [3:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    output reg         o_defrost,
    output reg         o_led,
    output wire        o_irq
);

// ****************************************************************
// Constants
// ****************************************************************
// Integer parameters held at full width, then cut to the counter widths
localparam [31:0] TICK_NORM_W = P_TICK_CYC;
localparam [31:0] TICK_TEST_W = P_TICK_CYC / `DDC_TEST_SPEEDUP;
localparam [31:0] LED_CYC_W   = P_LED_CYC;
localparam [31:0] DEMAND_S_W  = P_DEMAND_SEC;
localparam [31:0] BACKST_S_W  = P_BACKSTOP_SEC;
localparam [31:0] DEFR_S_W    = P_DEFROST_SEC;
// Counters cover one second of nominal clock and six hours in seconds
localparam [24:0] TICK_NORM = TICK_NORM_W[24:0];
localparam [24:0] TICK_TEST = TICK_TEST_W[24:0];
localparam [24:0] LED_CYC   = LED_CYC_W[24:0];
localparam [14:0] DEMAND_S  = DEMAND_S_W[14:0];
localparam [14:0] BACKST_S  = BACKST_S_W[14:0];
localparam [14:0] DEFR_S    = DEFR_S_W[14:0];
localparam        ST_IDLE   = 1'b0;
localparam        ST_DEFR   = 1'b1;

// Termination temperature from jumper position
function [7:0] term_temp;
    input [1:0] jmp;
    begin
        case (jmp)
            `DDC_JMP_50: term_temp = `DDC_TERM_50_F;
            `DDC_JMP_80: term_temp = `DDC_TERM_80_F;
            default:     term_temp = `DDC_TERM_70_F;
        endcase
    end
endfunction

// ****************************************************************
// State
// ****************************************************************
// Sequencer, timers and software-visible registers
reg                 state;
reg                 test_mode;
reg                 test_defr;
reg                 test_prev;
reg                 amb_prev;
reg                 coil_prev;
reg  [24:0]         tick_cnt;
reg  [14:0]         cold_sec;
reg  [14:0]         defr_sec;
reg  [24:0]         led_cnt;
reg  [3:0]          led_slot;
reg  [`DDC_EV_W-1:0] status;
reg  [`DDC_EV_W-1:0] mask;
reg                 ctrl_en;

// Start and finish qualifiers; the test pin acts on its rising edge only
wire               test_edge = i_test_short & ~test_prev;
wire               tick      = (tick_cnt == 25'h0);
wire signed [8:0]  delta     = $signed({i_amb_temp[7], i_amb_temp})
                             - $signed({i_coil_temp[7], i_coil_temp});
wire               cold      = $signed(i_coil_temp) < $signed(`DDC_COLD_F);
wire               cold_en   = cold | test_mode;
wire               coil_hot  = $signed(i_coil_temp) >= $signed(term_temp(i_term_jmp));
wire               big_delta = delta > $signed({P_DELTA_F[7], P_DELTA_F});
wire               cold_ok   = cold_en & (cold_sec >= DEMAND_S);
wire               demand    = cold_ok & (big_delta | i_amb_fail);
wire               backstop  = cold_sec >= BACKST_S;
wire               manual    = test_edge;
wire               can_start = ctrl_en & ~i_coil_fail;
wire               start     = (state == ST_IDLE) & can_start
                             & (demand | backstop | manual);
wire               finish    = (state == ST_DEFR)
                             & ((defr_sec >= DEFR_S) | coil_hot
                             | (test_defr & test_edge));
// Combinational event vector and next state
reg  [`DDC_EV_W-1:0] ev;
reg                 next_state;

// Event vector for status register
always @*
begin
    ev = {`DDC_EV_W{1'b0}};
    ev[`DDC_EV_START]    = start;
    ev[`DDC_EV_END]      = finish;
    ev[`DDC_EV_COIL_FLT] = i_coil_fail & ~coil_prev;
    ev[`DDC_EV_AMB_FLT]  = i_amb_fail & ~amb_prev;
end

// Next defrost state
always @*
begin
    case (state)
        ST_IDLE: next_state = start ? ST_DEFR : ST_IDLE;
        ST_DEFR: next_state = finish ? ST_IDLE : ST_DEFR;
        default: next_state = ST_IDLE;
    endcase
end

// ****************************************************************
// Timebase: one tick per second, 240 times faster in test mode
// ****************************************************************
always @(posedge i_core_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        tick_cnt <= 25'h0;
    // A test short restarts the prescaler so the fast rate applies at once
    else if (test_edge)
        tick_cnt <= TICK_TEST - 25'h1;
    else if (tick)
        tick_cnt <= (test_mode ? TICK_TEST : TICK_NORM) - 25'h1;
    else
        tick_cnt <= tick_cnt - 25'h1;
end

// ****************************************************************
// Defrost sequencing and run-time accumulation
// ****************************************************************
always @(posedge i_core_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        state     <= ST_IDLE;
        o_defrost <= 1'b0;
        cold_sec  <= 15'h0;
        defr_sec  <= 15'h0;
        test_mode <= 1'b0;
        test_defr <= 1'b0;
        test_prev <= 1'b0;
        amb_prev  <= 1'b0;
        coil_prev <= 1'b0;
    end
    else
    begin
        state     <= next_state;
        o_defrost <= (next_state == ST_DEFR);
        // Edge-detect registers for the test pin and both sensor faults
        test_prev <= i_test_short;
        amb_prev  <= i_amb_fail;
        coil_prev <= i_coil_fail;
        // Cold compressor run time, cleared when defrost ends; it saturates
        // so a very long cold spell cannot wrap and postpone the backstop
        if (finish)
            cold_sec <= 15'h0;
        else if (state == ST_IDLE && tick && i_comp_run && cold_en
                 && cold_sec != 15'h7FFF)
            cold_sec <= cold_sec + 15'h1;
        // Defrost duration timer
        if (state == ST_IDLE)
            defr_sec <= 15'h0;
        else if (tick && defr_sec != 15'h7FFF)
            defr_sec <= defr_sec + 15'h1;
        // Test mode entered by a short and left when any defrost ends, so a
        // short during a normal defrost cannot leave the timers running fast
        if (finish)
        begin
            test_mode <= 1'b0;
            test_defr <= 1'b0;
        end
        else if (start && manual)
        begin
            test_mode <= 1'b1;
            test_defr <= 1'b1;
        end
        else if (test_edge)
            test_mode <= 1'b1;
    end
end

// ****************************************************************
// LED flash codes
// ****************************************************************
reg  [1:0] code;

// Fault codes take priority over defrost indication
always @*
begin
    if (i_coil_fail)
        code = `DDC_CODE_COIL;
    else if (i_amb_fail)
        code = `DDC_CODE_AMB;
    else if (state == ST_DEFR)
        code = `DDC_CODE_DEFROST;
    else
        code = `DDC_CODE_STEADY;
end

// Sixteen slots per frame, a flash is one lit slot then one dark
// A code change mid-frame only alters the flashes still to come
always @(posedge i_core_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        led_cnt  <= 25'h0;
        led_slot <= 4'h0;
        o_led    <= 1'b0;
    end
    else
    begin
        if (led_cnt == 25'h0)
        begin
            led_cnt  <= LED_CYC - 25'h1;
            led_slot <= led_slot + 4'h1;
        end
        else
            led_cnt <= led_cnt - 25'h1;
        if (code == `DDC_CODE_STEADY)
            o_led <= 1'b1;
        else
            o_led <= (led_slot < {1'b0, code, 1'b0}) & ~led_slot[0];
    end
end

// ****************************************************************
// Register bus and interrupt
// ****************************************************************
// Write decodes; writes to unmapped addresses are dropped
wire wr_status = i_wr && (i_addr == `DDC_ADDR_STATUS);
wire wr_mask   = i_wr && (i_addr == `DDC_ADDR_MASK);
wire wr_ctrl   = i_wr && (i_addr == `DDC_ADDR_CTRL);

// Sticky events, write one to clear, a new event wins
always @(posedge i_core_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        status  <= {`DDC_EV_W{1'b0}};
        mask    <= `DDC_MASK_RST;
        ctrl_en <= `DDC_CTRL_RST;
    end
    else
    begin
        status <= (status & ~(wr_status ? i_wdata[`DDC_EV_W-1:0]
                                        : {`DDC_EV_W{1'b0}})) | ev;
        if (wr_mask)
            mask <= i_wdata[`DDC_EV_W-1:0];
        if (wr_ctrl)
            ctrl_en <= i_wdata[0];
    end
end

// Read data stands the cycle after the read strobe
// Every other cycle it returns to zero, so a stale read is never seen
always @(posedge i_core_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
        o_rdata <= 32'h0;
    else if (i_rd)
    begin
        case (i_addr)
            `DDC_ADDR_STATUS: o_rdata <= {28'h0, status};
            `DDC_ADDR_MASK:   o_rdata <= {28'h0, mask};
            `DDC_ADDR_CTRL:   o_rdata <= {31'h0, ctrl_en};
            `DDC_ADDR_STATE:  o_rdata <= {12'h0, defr_sec[14:0], 1'b0,
                                          code, test_mode, state};
            default:          o_rdata <= 32'h0;
        endcase
    end
    else
        o_rdata <= 32'h0;
end

// Level interrupt while any unmasked sticky event is pending
assign o_irq = |(status & mask);

endmodule // ddc_defrost_ctrl

// >>> tb/ddc_defrost_checker.sv
`timescale 1ns/10ps
`include "ddc_regs.vh"
// ****
// Port checker
// ****
module ddc_defrost_checker #(
    parameter P_TICK_CYC    = 240,
    parameter P_DEFROST_SEC = 6
) (
    input wire        i_core_clk,
    input wire        i_rst_n,
    input wire [7:0]  i_coil_temp,
    input wire        i_amb_fail,
    input wire        i_coil_fail,
    input wire        i_test_short,
    input wire [1:0]  i_term_jmp,
    input wire [3:0]  i_addr,
    input wire        i_wr,
    input wire [31:0] i_wdata,
    input wire        i_rd,
    input wire [31:0] o_rdata,
    input wire        o_defrost,
    input wire        o_led
);
    localparam int LIM = P_DEFROST_SEC * P_TICK_CYC + P_TICK_CYC + 4;
    reg         [31:0] on_cnt;
    reg                ctrl_on;
    wire signed [7:0]  term_f = (i_term_jmp == `DDC_JMP_50) ? `DDC_TERM_50_F :
        (i_term_jmp == `DDC_JMP_80) ? `DDC_TERM_80_F : `DDC_TERM_70_F;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // Cycles the current defrost has run
    always @(posedge i_core_clk or negedge i_rst_n)
        if (!i_rst_n)
            on_cnt <= 32'h0;
        else
            on_cnt <= o_defrost ? on_cnt + 32'h1 : 32'h0;
    // Start enable as last written over the bus
    always @(posedge i_core_clk or negedge i_rst_n)
        if (!i_rst_n)
            ctrl_on <= `DDC_CTRL_RST;
        else if (i_wr && i_addr == `DDC_ADDR_CTRL)
            ctrl_on <= i_wdata[0];
    a_coil_blocks: assert property (i_coil_fail && !o_defrost |=> !o_defrost)
        else $error("defrost began with coil sensor failed");
    a_test_start: assert property ($rose(i_test_short) && !o_defrost && ctrl_on
        && !i_coil_fail |=> o_defrost)
        else $error("test short did not start defrost");
    a_ctrl_blocks: assert property (!ctrl_on && !o_defrost |=> !o_defrost)
        else $error("defrost began with start disabled");
    a_term_end: assert property (o_defrost && $signed(i_coil_temp) >= term_f |=> !o_defrost)
        else $error("defrost kept past termination temperature");
    a_time_limit: assert property (on_cnt < LIM)
        else $error("defrost ran past its time limit");
    a_led_steady: assert property ((!o_defrost && !i_coil_fail && !i_amb_fail) [*3] |=> o_led)
        else $error("led not steady in normal operation");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data outside read answer");
    a_unmapped_rd: assert property (i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_state_read: assert property (i_rd && i_addr == `DDC_ADDR_STATE |=> o_rdata[0] == $past(o_defrost))
        else $error("state read disagrees with defrost output");
endmodule // ddc_defrost_checker

bind ddc_defrost_ctrl ddc_defrost_checker #(.P_TICK_CYC(P_TICK_CYC), .P_DEFROST_SEC(P_DEFROST_SEC))
    ddc_defrost_checker_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_coil_temp(i_coil_temp),
    .i_amb_fail(i_amb_fail), .i_coil_fail(i_coil_fail), .i_test_short(i_test_short),
    .i_term_jmp(i_term_jmp), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
    .i_rd(i_rd), .o_rdata(o_rdata),
    .o_defrost(o_defrost), .o_led(o_led));

// >>> tb/ddc_coil_model.sv
`timescale 1ns/10ps
// ****
// Outdoor coil sensor model
// ****
module ddc_coil_model (
    input  wire       i_core_clk,
    input  wire       i_rst_n,
    input  wire       i_defrost,
    input  wire       i_warm,
    input  wire [7:0] i_coil_set,
    output reg  [7:0] o_coil_temp
);
    // Coil warms a degree a cycle in defrost while i_warm is set and holds while it is clear; outside defrost it follows the set value
    always @(posedge i_core_clk or negedge i_rst_n)
        if (!i_rst_n)
            o_coil_temp <= 8'h00;
        else if (!i_defrost)
            o_coil_temp <= i_coil_set;
        else if (i_warm)
            o_coil_temp <= o_coil_temp + 8'h01;
endmodule // ddc_coil_model

// >>> tb/testbench.sv
`timescale 1ns/10ps
`include "ddc_regs.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module testbench;
    localparam P_TICK = 240;
    localparam P_DEF  = 100;  // Test defrost outlasts the coil warming to 80F
    reg         i_core_clk = 1'b0, i_rst_n = 1'b0, warm = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    reg         i_amb_fail = 1'b0, i_coil_fail = 1'b0, i_comp_run = 1'b0, i_test_short = 1'b0;
    reg  [7:0]  i_amb_temp = 8'h28;
    reg  [1:0]  i_term_jmp = 2'h0;
    reg  [3:0]  i_addr = 4'h0;
    reg  [31:0] i_wdata = 32'h0, d;
    wire [7:0]  coil_temp;
    wire [31:0] o_rdata;
    wire        o_defrost, o_led, o_irq;
    integer     error_cnt = 0, check_count = 0, cyc = 0, j;
    initial forever #25 i_core_clk = ~i_core_clk;
    ddc_coil_model ddc_coil_model_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_defrost(o_defrost), .i_warm(warm), .i_coil_set(8'h14), .o_coil_temp(coil_temp));
    ddc_defrost_ctrl #(.P_TICK_CYC(P_TICK), .P_LED_CYC(4), .P_DEMAND_SEC(4),
        .P_BACKSTOP_SEC(12), .P_DEFROST_SEC(P_DEF)) ddc_defrost_ctrl_i (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_amb_temp(i_amb_temp),
        .i_coil_temp(coil_temp), .i_amb_fail(i_amb_fail), .i_coil_fail(i_coil_fail),
        .i_comp_run(i_comp_run), .i_test_short(i_test_short), .i_term_jmp(i_term_jmp),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_defrost(o_defrost), .o_led(o_led), .o_irq(o_irq));
    // Bus write and read
    task wr(input [3:0] a, input [31:0] v);
    begin
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    end
    endtask
    task rd(input [3:0] a, output [31:0] v);
    begin
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    end
    endtask
    // Short the test pins for two cycles
    task short_pins;
    begin
        @(posedge i_core_clk);
        i_test_short <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_test_short <= 1'b0;
        #1;
    end
    endtask
    // Wait for a defrost level and check the wait length
    task wait_def(input lvl, input integer lo, input integer hi, input [8*8:1] nm);
        integer k;
    begin
        k = 0;
        while (o_defrost !== lvl && k <= hi)
        begin
            @(posedge i_core_clk);
            #1 k = k + 1;
        end
        `CHK(nm, 1'b1, k >= lo && k <= hi)
    end
    endtask
    // Lit cycles in one flash frame of 64 cycles
    task led_cnt(input integer e);
        integer k;
    begin
        k = 0;
        repeat (70) @(posedge i_core_clk);
        repeat (64)
        begin
            @(posedge i_core_clk);
            #1 k = k + o_led;
        end
        `CHK("led lit", e, k)
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    // Run limit
    always @(posedge i_core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 12000)
        begin
            error_cnt = error_cnt + 1;
            end_sim;
        end
    end
    initial
    begin
        repeat (4) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        rd(`DDC_ADDR_MASK, d);
        `CHK("mask", 32'h0, d)
        rd(`DDC_ADDR_CTRL, d);
        `CHK("ctrl", 32'h1, d)
        rd(4'h6, d);
        `CHK("unmapped", 32'h0, d)
        // Start refused while the enable bit is clear
        wr(`DDC_ADDR_CTRL, 32'h0);
        short_pins;
        repeat (3) @(posedge i_core_clk);
        #1;
        `CHK("ctrl off", 1'b0, o_defrost)
        wr(`DDC_ADDR_CTRL, 32'h1);
        rd(`DDC_ADDR_CTRL, d);
        `CHK("ctrl on", 32'h1, d)
        // Test defrosts ending at each jumper temperature
        warm <= 1'b1;
        for (j = 0; j < 3; j = j + 1)
        begin
            i_term_jmp <= (j == 0) ? `DDC_JMP_50 : (j == 1) ? `DDC_JMP_80 : 2'h0;
            short_pins;
            wait_def(1'b1, 0, 0, "start");
            rd(`DDC_ADDR_STATE, d);
            `CHK("state", 32'h3, d & 32'h3)
            wait_def(1'b0, 10, 80, "term");
            `CHK("end coil", ((j == 0) ? `DDC_TERM_50_F : (j == 1) ? `DDC_TERM_80_F :
                `DDC_TERM_70_F) + 8'h01, coil_temp)
            `CHK("irq masked", 1'b0, o_irq)
            rd(`DDC_ADDR_STATUS, d);
            `CHK("status", 32'h3, d)
            wr(`DDC_ADDR_STATUS, 32'hF);
        end
        $display("test jumper done");
        wr(`DDC_ADDR_MASK, 32'h1);
        warm <= 1'b0;
        short_pins;
        `CHK("irq", 1'b1, o_irq)
        short_pins;
        wait_def(1'b0, 0, 0, "abort");
        wr(`DDC_ADDR_STATUS, 32'hF);
        `CHK("irq clear", 1'b0, o_irq)
        short_pins;
        wait_def(1'b0, P_DEF - 3, P_DEF + 4, "limit");
        $display("test abort done");
        // Demand start, then backstop with a small difference
        warm <= 1'b1;
        i_comp_run <= 1'b1;
        wait_def(1'b1, 3 * P_TICK - 10, 4 * P_TICK + 5, "demand");
        wait_def(1'b0, 10, 80, "d end");
        i_amb_temp <= 8'h19;
        warm <= 1'b0;
        wait_def(1'b1, 11 * P_TICK - 10, 12 * P_TICK + 5, "backstop");
        led_cnt(4);
        warm <= 1'b1;
        wait_def(1'b0, 10, 80, "b end");
        $display("test demand done");
        i_amb_fail <= 1'b1;
        led_cnt(12);
        wait_def(1'b1, 2 * P_TICK - 10, 4 * P_TICK + 5, "amb fail");
        wait_def(1'b0, 10, 80, "a end");
        i_amb_fail <= 1'b0;
        i_coil_fail <= 1'b1;
        short_pins;
        led_cnt(8);
        repeat (5 * P_TICK) @(posedge i_core_clk);
        #1;
        `CHK("no defrost", 1'b0, o_defrost)
        rd(`DDC_ADDR_STATUS, d);
        `CHK("coil fault", 1'b1, d[`DDC_EV_COIL_FLT])
        $display("test faults done");
        end_sim;
    end
endmodule // testbench
